/* include/lls_pkg.sv */
// Package for the link indicator and host mode strap block
// Contract
// RULE1: Link, speed, duplex indicators active low, both modes
// RULE2: Activity steady when idle, high when link down
// RULE3: Activity flashes during traffic while link up
// RULE4: Collision indicator low on transmit collision
// RULE5: Strap 0000 serial, 010X parallel host mode
// RULE6: Internal clock 25MHz low-frequency or 100MHz normal
// RULE7: Strap sampled once after reset, then held
package lls_pkg;
  localparam logic [3:0] STRAP_SERIAL = 4'h0;
  localparam logic [3:0] STRAP_PAR_MASK = 4'hE;
  localparam logic [3:0] STRAP_PAR = 4'h4;
  localparam int REF_CLK_MHZ = 25;
  localparam int LOWF_CLK_MHZ = 25;
  localparam int NORM_CLK_MHZ = 100;
  localparam int SYS_CLK_MHZ = 10;
  localparam int FLASH_HALF_MS = 50;
  localparam int FLASH_HALF_CYC = FLASH_HALF_MS * 1000 * SYS_CLK_MHZ;
  localparam logic FLASH_RESET = 1'h0;
  localparam logic LED_DARK = 1'h1;
  localparam int RESET_CLK_MHZ = NORM_CLK_MHZ;

  typedef enum logic [2:0] {
    LLS_HOST_NONE = 3'h1,
    LLS_HOST_SERIAL = 3'h2,
    LLS_HOST_PARALLEL = 3'h4
  } lls_host_t;

  typedef struct packed {
    logic link_up;
    logic speed_100;
    logic full_duplex;
    logic traffic;
    logic collision;
  } lls_status_t;

  typedef struct packed {
    logic link_up_led_n;
    logic speed_100_led_n;
    logic full_duplex_led_n;
    logic traffic_activity_led_n;
    logic collision_led_n;
  } lls_leds_t;
endpackage : lls_pkg

/* core/lls_flasher.sv */
// Blink generator for the traffic activity indicator
`timescale 1ns/10ps
module lls_flasher #(
  parameter int HALF_CYC = lls_pkg::FLASH_HALF_CYC
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic run,
  output logic phase
);
  localparam int CW = $clog2(HALF_CYC + 1);
  localparam logic [CW-1:0] LAST = CW'(HALF_CYC - 1);
  logic [CW-1:0] cnt_reg;
  logic [CW-1:0] cnt_next;
  logic phase_reg;
  logic phase_next;
  wire wrap = (cnt_reg == LAST);

  // Counter parks while idle so each burst starts with a full lit half
  always_comb begin
    cnt_next = cnt_reg;
    phase_next = phase_reg;
    if (!run) begin
      cnt_next = '0;
      phase_next = lls_pkg::FLASH_RESET;
    end else if (wrap) begin
      cnt_next = '0;
      phase_next = ~phase_reg;
    end else begin
      cnt_next = cnt_reg + CW'(1);
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      cnt_reg <= '0;
      phase_reg <= lls_pkg::FLASH_RESET;
    end else begin
      cnt_reg <= cnt_next;
      phase_reg <= phase_next;
    end
  end

  assign phase = phase_reg;
endmodule : lls_flasher

/* core/lls_top.sv */
// Link indicator drivers, host mode strap decode and internal clock mode select
`timescale 1ns/10ps
module lls_top #(
  parameter int FLASH_HALF_CYC = lls_pkg::FLASH_HALF_CYC
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire lls_pkg::lls_status_t phy_status,
  input wire logic [3:0] host_if_strap,
  input wire logic low_freq_mode,
  output lls_pkg::lls_leds_t leds,
  output lls_pkg::lls_host_t host_mode,
  output logic host_mode_valid,
  output logic [7:0] int_clk_mhz
);
  ////////////////////////////////////////////////////////////////
  // Local types

  // One-hot sequencer for the strap capture
  typedef enum logic [1:0] {
    LLS_CAP_WAIT = 2'h1,
    LLS_CAP_HELD = 2'h2
  } lls_cap_state_t;

  ////////////////////////////////////////////////////////////////
  // Functions

  // Exact match: every strap bit counts
  function automatic logic strap_is_serial(input logic [3:0] s);
    strap_is_serial = (s == lls_pkg::STRAP_SERIAL);
  endfunction : strap_is_serial

  // Lowest strap bit is a don't-care for the parallel bus
  function automatic logic strap_is_parallel(input logic [3:0] s);
    strap_is_parallel = ((s & lls_pkg::STRAP_PAR_MASK) == lls_pkg::STRAP_PAR);
  endfunction : strap_is_parallel

  // Unused codes map to none, so a mis-strapped board stays visible
  function automatic lls_pkg::lls_host_t decode_strap(input logic [3:0] s);
    if (strap_is_serial(s)) begin
      decode_strap = lls_pkg::LLS_HOST_SERIAL;
    end else if (strap_is_parallel(s)) begin
      decode_strap = lls_pkg::LLS_HOST_PARALLEL;
    end else begin
      decode_strap = lls_pkg::LLS_HOST_NONE;
    end
  endfunction : decode_strap

  // Pin level for an active-high condition on an active-low LED
  function automatic logic led_level(input logic on);
    led_level = ~on;
  endfunction : led_level

  function automatic logic [7:0] clk_rate(input logic low_freq);
    if (low_freq) begin
      clk_rate = 8'(lls_pkg::LOWF_CLK_MHZ);
    end else begin
      clk_rate = 8'(lls_pkg::NORM_CLK_MHZ);
    end
  endfunction : clk_rate

  ////////////////////////////////////////////////////////////////
  // Strap capture

  wire lls_pkg::lls_host_t strap_mode = decode_strap(host_if_strap); // RULE5
  lls_cap_state_t cap_state_reg;
  lls_cap_state_t cap_state_next;
  lls_pkg::lls_host_t mode_reg;
  lls_pkg::lls_host_t mode_next;
  logic valid_reg;
  logic valid_next;

  // Capture on the first edge after release; later strap motion is ignored,
  // so strap pins reused by board logic after reset cannot flip the mode
  always_comb begin
    cap_state_next = cap_state_reg;
    mode_next = mode_reg;
    valid_next = valid_reg;
    case (cap_state_reg)
      LLS_CAP_WAIT: begin
        cap_state_next = LLS_CAP_HELD;
        mode_next = strap_mode; // RULE7
        valid_next = 1'h1;
      end
      LLS_CAP_HELD: begin
        cap_state_next = LLS_CAP_HELD;
      end
      default: begin
        // Illegal code: go back and recapture rather than lock up
        cap_state_next = LLS_CAP_WAIT;
        mode_next = lls_pkg::LLS_HOST_NONE;
        valid_next = 1'h0;
      end
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      cap_state_reg <= LLS_CAP_WAIT;
    end else begin
      cap_state_reg <= cap_state_next;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      mode_reg <= lls_pkg::LLS_HOST_NONE;
    end else begin
      mode_reg <= mode_next;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      valid_reg <= 1'h0;
    end else begin
      valid_reg <= valid_next;
    end
  end

  ////////////////////////////////////////////////////////////////
  // Indicator inputs

  wire link_up = phy_status.link_up;
  wire speed_100 = phy_status.speed_100;
  wire full_duplex = phy_status.full_duplex;
  wire traffic = phy_status.traffic;
  wire collision = phy_status.collision;

  ////////////////////////////////////////////////////////////////
  // Activity blink

  // A dead link keeps the LED dark, so only a live link may blink
  wire flash_run = link_up & traffic; // RULE3
  logic flash_phase;

  lls_flasher #(
    .HALF_CYC(FLASH_HALF_CYC)
  ) lls_flasher_inst (
    .clk_sys(clk_sys),
    .rst(rst),
    .run(flash_run),
    .phase(flash_phase)
  );

  // Phase gated by traffic: the LED settles on the first edge after
  // traffic stops instead of finishing a dark half
  wire activity_dark = flash_run & flash_phase; // RULE3
  wire activity_lit = link_up & ~activity_dark; // RULE2

  ////////////////////////////////////////////////////////////////
  // Indicator next values

  // Indicators work in either host mode, so none is gated by the strap
  wire link_led_next = led_level(link_up); // RULE1
  wire speed_led_next = led_level(speed_100); // RULE1
  wire duplex_led_next = led_level(full_duplex); // RULE1
  wire activity_led_next = led_level(activity_lit); // RULE2 RULE3
  wire collision_led_next = led_level(collision); // RULE4

  ////////////////////////////////////////////////////////////////
  // Indicator registers

  // One flop per pin; reset leaves every LED dark
  logic link_led_reg;
  logic speed_led_reg;
  logic duplex_led_reg;
  logic activity_led_reg;
  logic collision_led_reg;

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      link_led_reg <= lls_pkg::LED_DARK;
    end else begin
      link_led_reg <= link_led_next;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      speed_led_reg <= lls_pkg::LED_DARK;
    end else begin
      speed_led_reg <= speed_led_next;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      duplex_led_reg <= lls_pkg::LED_DARK;
    end else begin
      duplex_led_reg <= duplex_led_next;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      activity_led_reg <= lls_pkg::LED_DARK;
    end else begin
      activity_led_reg <= activity_led_next;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      collision_led_reg <= lls_pkg::LED_DARK;
    end else begin
      collision_led_reg <= collision_led_next;
    end
  end

  ////////////////////////////////////////////////////////////////
  // Internal clock rate selection

  // Only the chosen rate is reported; the multiplier itself sits outside
  // and follows it. Reset picks the normal rate.
  wire [7:0] clk_next = clk_rate(low_freq_mode); // RULE6
  logic [7:0] clk_reg;

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      clk_reg <= 8'(lls_pkg::RESET_CLK_MHZ);
    end else begin
      clk_reg <= clk_next;
    end
  end

  ////////////////////////////////////////////////////////////////
  // Outputs, each straight from a flip-flop

  assign leds = {
    link_led_reg,
    speed_led_reg,
    duplex_led_reg,
    activity_led_reg,
    collision_led_reg
  };
  assign host_mode = mode_reg;
  assign host_mode_valid = valid_reg;
  assign int_clk_mhz = clk_reg;
endmodule : lls_top

/* testbench/lls_monitor.sv */
// Assertion checker for the indicator block
`timescale 1ns/10ps
module lls_monitor #(parameter int FLASH_HALF_CYC = 4) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire lls_pkg::lls_status_t phy_status,
  input wire logic [3:0] host_if_strap,
  input wire logic low_freq_mode,
  input wire lls_pkg::lls_leds_t leds,
  input wire lls_pkg::lls_host_t host_mode,
  input wire logic host_mode_valid,
  input wire logic [7:0] int_clk_mhz
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);
  wire logic [2:0] dec = host_if_strap == 4'h0 ? 3'h2 : (host_if_strap[3:1] == 3'h2 ? 3'h4 : 3'h1);
  AST_STATUS: assert property (1 |=> leds[4:2] == ~$past(phy_status[4:2])) else $error("status");
  AST_ACT_DOWN: assert property (!phy_status.link_up |=> leds.traffic_activity_led_n) else $error("act");
  AST_ACT_IDLE: assert property (phy_status.link_up && !phy_status.traffic |=> !leds.traffic_activity_led_n)
    else $error("idle");
  // Needs two half periods inside eight cycles, so only holds for short flash settings
  AST_FLASH: assert property ((phy_status.link_up && phy_status.traffic) [*8] |->
    leds.traffic_activity_led_n != $past(leds.traffic_activity_led_n, FLASH_HALF_CYC)) else $error("flash");
  AST_COL: assert property (1 |=> leds.collision_led_n == !$past(phy_status.collision)) else $error("col");
  AST_DECODE: assert property ($fell(rst) |=> host_mode_valid && host_mode == $past(dec)) else $error("dec");
  AST_CLK: assert property (1 |=> int_clk_mhz == ($past(low_freq_mode) ? 8'h19 : 8'h64)) else $error("clk");
  AST_HOLD: assert property (host_mode_valid |=> host_mode_valid && $stable(host_mode)) else $error("hold");
endmodule : lls_monitor
bind lls_top lls_monitor #(.FLASH_HALF_CYC(FLASH_HALF_CYC)) lls_monitor_inst (.clk_sys, .rst, .phy_status,
  .host_if_strap, .low_freq_mode, .leds, .host_mode, .host_mode_valid, .int_clk_mhz);

/* testbench/lls_board_model.sv */
// Board strap wiring model
`timescale 1ns/10ps
module lls_board_model (
  input wire logic [1:0] strap_sel,
  output logic [3:0] host_if_strap
);
  // Serial, parallel with either low bit, and one unused code
  assign host_if_strap = strap_sel == 2'h0 ? 4'h0 :
    (strap_sel == 2'h1 ? 4'h4 : (strap_sel == 2'h2 ? 4'h5 : 4'hA));
endmodule : lls_board_model

/* testbench/lls_tb_top.sv */
// Testbench for the indicator and strap block
`timescale 1ns/10ps
module lls_tb_top;
  logic clk_sys = 1'h0;
  logic rst = 1'h1;
  logic low_freq_mode = 1'h0;
  logic [1:0] strap_sel = 2'h0;
  logic [3:0] host_if_strap;
  logic host_mode_valid;
  logic [7:0] int_clk_mhz;
  lls_pkg::lls_status_t phy_status = 5'h00;
  lls_pkg::lls_leds_t leds;
  lls_pkg::lls_host_t host_mode;
  int bad_count = 0;
  int check_count = 0;
  initial forever #50 clk_sys = ~clk_sys;
  lls_board_model lls_board_model_inst (.strap_sel(strap_sel), .host_if_strap(host_if_strap));
  lls_top #(.FLASH_HALF_CYC(4)) lls_top_inst (.clk_sys(clk_sys), .rst(rst), .phy_status(phy_status),
    .host_if_strap(host_if_strap), .low_freq_mode(low_freq_mode), .leds(leds), .host_mode(host_mode),
    .host_mode_valid(host_mode_valid), .int_clk_mhz(int_clk_mhz));
  task check(input logic [7:0] seen, input logic [7:0] want);
    check_count++;
    if (seen !== want) begin
      bad_count++;
      $display("wrong value at %0t: %h not %h", $time, seen, want);
    end
  endtask : check
  task step(input int n);
    repeat (n) @(posedge clk_sys);
    #10;
  endtask : step
  task t_status;
    for (int i = 0; i < 16; i++) begin
      phy_status = {i[3:1], 1'h0, i[0]};
      step(1);
      check(leds, {~i[3:1], ~i[3], ~i[0]});
    end
    $display("status done");
  endtask : t_status
  task t_flash;
    phy_status = 5'h12;
    step(1);
    for (int n = 0; n < 14; n++) begin
      check(leds.traffic_activity_led_n, n[2]);
      step(1);
    end
    phy_status = 5'h10;
    step(1);
    check(leds.traffic_activity_led_n, 1'h0);
    step(2);
    check(leds.traffic_activity_led_n, 1'h0);
    phy_status = 5'h02;
    step(1);
    check(leds.traffic_activity_led_n, 1'h1);
    $display("flash done");
  endtask : t_flash
  task t_clk;
    low_freq_mode = 1'h1;
    step(1);
    check(int_clk_mhz, 8'h19);
    low_freq_mode = 1'h0;
    step(1);
    check(int_clk_mhz, 8'h64);
    $display("clock done");
  endtask : t_clk
  task t_strap;
    logic [2:0] want [4] = '{3'h2, 3'h4, 3'h4, 3'h1};
    phy_status = 5'h1D;
    for (int s = 0; s < 4; s++) begin
      rst = 1'h1;
      low_freq_mode = 1'h1;
      strap_sel = s[1:0];
      step(2);
      check({host_mode_valid, host_mode}, 4'h1);
      check(leds, 5'h1F);
      check(int_clk_mhz, 8'h64);
      rst = 1'h0;
      low_freq_mode = 1'h0;
      step(1);
      check(host_mode, want[s]);
      strap_sel = ~s[1:0];
      step(2);
      check({host_mode_valid, host_mode}, {1'h1, want[s]});
    end
    $display("strap done");
  endtask : t_strap
  task final_report;
    $display("checks %0d errors %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : final_report
  initial begin
    step(12);
    rst = 1'h0;
    step(1);
    t_status;
    t_flash;
    t_clk;
    t_strap;
    final_report;
  end
endmodule : lls_tb_top
